// ---- include/bfs_pkg.sv ----
// constants and types of the buck fault and soft-start sequencer
// What this block does
// - after lockout clears with enable high, feedback is tested for a short first
// - a shorted feedback network keeps the ramp held and switching off
// - enable input already reflects the internal pull-up, so open enable starts
// - ramp at regulation point means regulated; only undervoltage fault inhibited until arm point
// - ramp advances one step per oscillator cycle, so time scales with clock
// - lockout, or an enable fall outside the fault states, discharges the ramp and resets the controller
// - low side stays out of full synchronous mode until ramp reaches 95 percent
// - feedback under threshold 16 cycles latches fault, armed only after arm point
// - switch node high while low side on latches fault at once
// - overvoltage and high-side short checks stay armed through soft-start
// - over-temperature latches fault; restart only once temperature is low again
// - after fault enable is sunk to low threshold, then released to recharge
// - restart follows enable termination: low off, held high latched, open restarts
// - power good low out of regulation and never high before the arm point
// - high-side pulse ends when summed signal crosses current limit
// - high-side pulse ends when summed signal crosses error amplifier level
// - 16 consecutive current-limit cycles latch the fault
// - overcurrent may latch the fault during soft-start
package bfs_pkg;
  localparam int SS_W = 12;
  // ramp counts in cycles; ratio 0.8:0.76:1.0 of full scale
  localparam logic [SS_W-1:0] SS_REG_PT  = 12'h800;
  localparam logic [SS_W-1:0] SS_SYNC_PT = 12'h79a;
  localparam logic [SS_W-1:0] SS_ARM_PT  = 12'ha00;
  localparam int UV_CYCLES = 16;
  localparam int OV_CYCLES = 2;
  localparam int OC_CYCLES = 16;
  localparam logic [4:0] CNT_ONE = 5'h01;

  typedef enum {ST_OFF, ST_FB_TEST, ST_RAMP, ST_RUN, ST_FAULT_SINK, ST_FAULT_WAIT} bfs_state_t;

  typedef struct packed {
    logic supply_ok;
    logic enable_high;
    logic enable_low_thr;
    logic fb_short;
    logic fb_uv;
    logic fb_ov;
    logic fb_pg_window;
    logic switch_node_high;
    logic temp_hot;
    logic temp_cool;
    logic cur_limit_cross;
    logic err_amp_cross;
    logic clock_cycle_start;
  } bfs_in_t;

  typedef struct packed {
    logic high_side_on;
    logic low_side_sync;
    logic low_side_diode;
    logic enable_sink;
    logic power_good_out;
    logic fault_latched;
  } bfs_out_t;

  typedef struct packed {
    bfs_state_t    st;
    logic [SS_W-1:0] ramp;
    logic [4:0]    uv_cnt;
    logic [4:0]    ov_cnt;
    logic [4:0]    oc_cnt;
    logic          oc_hit;
    logic          en_prev;
    bfs_out_t      o;
  } bfs_reg_t;
endpackage

// ---- rtl/bfs_sequencer.sv ----
// buck fault, soft-start and restart sequencer
`timescale 1ns/100ps
module bfs_sequencer (
  input  wire logic            clk,
  input  wire logic            srst,
  input  wire bfs_pkg::bfs_in_t  in_i,
  output bfs_pkg::bfs_out_t      out_o,
  output logic [bfs_pkg::SS_W-1:0] ramp_o
);
  bfs_pkg::bfs_reg_t s_q;
  bfs_pkg::bfs_reg_t s_d;
  logic armed;
  logic fault_now;
  logic pulse_end;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.en_prev = in_i.enable_high;
    armed = (s_q.ramp >= bfs_pkg::SS_ARM_PT);
    pulse_end = in_i.cur_limit_cross | in_i.err_amp_cross;
    // uv filter only after arm point
    if (in_i.fb_uv && armed && s_q.uv_cnt < 5'(bfs_pkg::UV_CYCLES)) begin
      s_d.uv_cnt = s_q.uv_cnt + bfs_pkg::CNT_ONE;
    end else if (!in_i.fb_uv || !armed) begin
      s_d.uv_cnt = '0;
    end
    if (in_i.fb_ov && s_q.ov_cnt < 5'(bfs_pkg::OV_CYCLES)) begin
      s_d.ov_cnt = s_q.ov_cnt + bfs_pkg::CNT_ONE;
    end else if (!in_i.fb_ov) begin
      s_d.ov_cnt = '0;
    end
    // one overcurrent verdict per switching cycle, counted at cycle start
    if (in_i.cur_limit_cross) begin
      s_d.oc_hit = 1'b1;
    end
    if (in_i.clock_cycle_start) begin
      s_d.oc_hit = 1'b0;
      if (s_q.oc_hit && s_q.oc_cnt < 5'(bfs_pkg::OC_CYCLES)) begin
        s_d.oc_cnt = s_q.oc_cnt + bfs_pkg::CNT_ONE;
      end else if (!s_q.oc_hit) begin
        s_d.oc_cnt = '0;
      end
    end
    fault_now = (s_q.uv_cnt >= 5'(bfs_pkg::UV_CYCLES))
              | (s_q.ov_cnt >= 5'(bfs_pkg::OV_CYCLES))
              | (in_i.switch_node_high && s_q.o.low_side_sync)
              | in_i.temp_hot
              | (s_q.oc_cnt >= 5'(bfs_pkg::OC_CYCLES));
    case (s_q.st)
      bfs_pkg::ST_OFF: begin
        s_d.ramp = '0;
        if (in_i.supply_ok && in_i.enable_high) begin
          s_d.st = bfs_pkg::ST_FB_TEST;
        end
      end
      bfs_pkg::ST_FB_TEST: begin
        // shorted divider keeps ramp held indefinitely
        if (!in_i.fb_short) begin
          s_d.st = bfs_pkg::ST_RAMP;
        end
      end
      bfs_pkg::ST_RAMP: begin
        if (in_i.clock_cycle_start) begin
          s_d.ramp = s_q.ramp + 12'h001;
        end
        if (armed) begin
          s_d.st = bfs_pkg::ST_RUN;
        end
      end
      bfs_pkg::ST_RUN: begin
      end
      bfs_pkg::ST_FAULT_SINK: begin
        s_d.ramp = '0;
        // latched-off if enable is held high externally
        if (in_i.enable_low_thr && in_i.temp_cool) begin
          s_d.st = bfs_pkg::ST_FAULT_WAIT;
        end
      end
      bfs_pkg::ST_FAULT_WAIT: begin
        s_d.ramp = '0;
        if (in_i.enable_high) begin
          s_d.st = bfs_pkg::ST_FB_TEST;
        end
      end
      default: s_d.st = bfs_pkg::ST_OFF;
    endcase
    if ((s_q.st == bfs_pkg::ST_RAMP || s_q.st == bfs_pkg::ST_RUN) && fault_now) begin
      s_d.st = bfs_pkg::ST_FAULT_SINK;
      s_d.ramp = '0;
    end
    if (s_d.st == bfs_pkg::ST_FAULT_SINK || s_d.st == bfs_pkg::ST_FAULT_WAIT) begin
      s_d.uv_cnt = '0;
      s_d.ov_cnt = '0;
      s_d.oc_cnt = '0;
    end
    // lockout restarts everything, fault states included; an enable fall only outside the fault states
    if (!in_i.supply_ok || (s_q.en_prev && !in_i.enable_high &&
        s_q.st != bfs_pkg::ST_FAULT_SINK && s_q.st != bfs_pkg::ST_FAULT_WAIT)) begin
      s_d.st = bfs_pkg::ST_OFF;
      s_d.ramp = '0;
      s_d.uv_cnt = '0;
      s_d.ov_cnt = '0;
      s_d.oc_cnt = '0;
      s_d.oc_hit = 1'b0;
    end
    s_d.o.fault_latched = (s_d.st == bfs_pkg::ST_FAULT_SINK) || (s_d.st == bfs_pkg::ST_FAULT_WAIT);
    s_d.o.enable_sink = (s_d.st == bfs_pkg::ST_FAULT_SINK);
    // pulse set at cycle start, cut by either comparator
    if ((s_d.st == bfs_pkg::ST_RAMP || s_d.st == bfs_pkg::ST_RUN) && !fault_now) begin
      if (pulse_end) begin
        s_d.o.high_side_on = 1'b0;
      end else if (in_i.clock_cycle_start) begin
        s_d.o.high_side_on = 1'b1;
      end
      s_d.o.low_side_sync = (s_d.ramp >= bfs_pkg::SS_SYNC_PT) && !s_d.o.high_side_on;
      s_d.o.low_side_diode = !s_d.o.high_side_on;
    end else begin
      s_d.o.high_side_on = 1'b0;
      s_d.o.low_side_sync = 1'b0;
      s_d.o.low_side_diode = 1'b0;
    end
    s_d.o.power_good_out = (s_d.st == bfs_pkg::ST_RUN) && in_i.fb_pg_window
                           && (s_d.ramp >= bfs_pkg::SS_ARM_PT);
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '{st: bfs_pkg::ST_OFF, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign out_o  = s_q.o;
  assign ramp_o = s_q.ramp;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  property p_pg_after_arm;
    @(posedge clk) disable iff (srst) s_q.o.power_good_out |-> s_q.ramp >= bfs_pkg::SS_ARM_PT;
  endproperty
  a_pg_after_arm: assert property (p_pg_after_arm) else $error("power good before arm point");

  property p_fault_drives_off;
    @(posedge clk) disable iff (srst)
      s_q.o.fault_latched |-> !s_q.o.high_side_on && !s_q.o.low_side_sync && s_q.ramp == '0;
  endproperty
  a_fault_drives_off: assert property (p_fault_drives_off) else $error("drive active in fault");

  property p_sync_gate;
    @(posedge clk) disable iff (srst) s_q.o.low_side_sync |-> s_q.ramp >= bfs_pkg::SS_SYNC_PT;
  endproperty
  a_sync_gate: assert property (p_sync_gate) else $error("sync low side too early");

  property p_short_holds;
    @(posedge clk) disable iff (srst)
      (s_q.st == bfs_pkg::ST_FB_TEST && in_i.fb_short && in_i.supply_ok) |=> s_q.ramp == '0 && !s_q.o.high_side_on;
  endproperty
  a_short_holds: assert property (p_short_holds) else $error("ramp released on short");

  property p_ov_fault;
    @(posedge clk) disable iff (srst)
      ((s_q.st == bfs_pkg::ST_RAMP || s_q.st == bfs_pkg::ST_RUN) && in_i.supply_ok && in_i.enable_high
       && in_i.fb_ov) [*3]
      |=> s_q.o.fault_latched || !in_i.supply_ok;
  endproperty
  a_ov_fault: assert property (p_ov_fault) else $error("overvoltage not latched");

  property p_hs_short;
    @(posedge clk) disable iff (srst)
      ((s_q.st == bfs_pkg::ST_RAMP || s_q.st == bfs_pkg::ST_RUN) && s_q.o.low_side_sync
       && in_i.switch_node_high && in_i.supply_ok && in_i.enable_high)
      |=> s_q.o.fault_latched;
  endproperty
  a_hs_short: assert property (p_hs_short) else $error("high side short missed");

  property p_lockout_reset;
    @(posedge clk) disable iff (srst) !in_i.supply_ok |=> s_q.st == bfs_pkg::ST_OFF && s_q.ramp == '0;
  endproperty
  a_lockout_reset: assert property (p_lockout_reset) else $error("lockout did not reset");

  property p_uv_disarmed;
    @(posedge clk) disable iff (srst) (s_q.ramp < bfs_pkg::SS_ARM_PT) |-> s_q.uv_cnt == '0;
  endproperty
  a_uv_disarmed: assert property (p_uv_disarmed) else $error("uv counted before arm point");

  property p_ramp_step;
    @(posedge clk) disable iff (srst)
      (s_q.st == bfs_pkg::ST_RAMP && !in_i.clock_cycle_start) |=> s_q.ramp <= $past(s_q.ramp);
  endproperty
  a_ramp_step: assert property (p_ramp_step) else $error("ramp moved without clock cycle");

  c_run: cover property (@(posedge clk) s_q.st == bfs_pkg::ST_RUN && s_q.o.power_good_out);
  c_fault: cover property (@(posedge clk) s_q.st == bfs_pkg::ST_FAULT_SINK);
  c_restart: cover property (@(posedge clk) s_q.st == bfs_pkg::ST_FAULT_WAIT ##1 s_q.st == bfs_pkg::ST_FB_TEST);
  c_sync: cover property (@(posedge clk) s_q.o.low_side_sync);
  c_ov: cover property (@(posedge clk) s_q.ov_cnt == 5'(bfs_pkg::OV_CYCLES));

  // ------------------------------------------------------------
  // sequencing and restart checks
  // ------------------------------------------------------------
  property p_fb_test_first;
    @(posedge clk) disable iff (srst)
      s_q.st == bfs_pkg::ST_OFF |=> s_q.st != bfs_pkg::ST_RAMP;
  endproperty
  a_fb_test_first: assert property (p_fb_test_first) else $error("ramp began without feedback test");

  property p_short_stays;
    @(posedge clk) disable iff (srst)
      (s_q.st == bfs_pkg::ST_FB_TEST && in_i.fb_short && in_i.supply_ok && in_i.enable_high)
      |=> s_q.st == bfs_pkg::ST_FB_TEST;
  endproperty
  a_short_stays: assert property (p_short_stays) else $error("left feedback test on short");

  property p_open_enable_starts;
    @(posedge clk) disable iff (srst)
      (s_q.st == bfs_pkg::ST_OFF && in_i.supply_ok && in_i.enable_high) |=> s_q.st == bfs_pkg::ST_FB_TEST;
  endproperty
  a_open_enable_starts: assert property (p_open_enable_starts) else $error("no start with enable high");

  property p_run_at_arm;
    @(posedge clk) disable iff (srst)
      (s_q.st == bfs_pkg::ST_RAMP && armed && in_i.supply_ok && in_i.enable_high && !fault_now)
      |=> s_q.st == bfs_pkg::ST_RUN;
  endproperty
  a_run_at_arm: assert property (p_run_at_arm) else $error("run not entered at arm point");

  property p_ramp_moves;
    @(posedge clk) disable iff (srst)
      (s_q.st == bfs_pkg::ST_RAMP && in_i.clock_cycle_start && in_i.supply_ok && in_i.enable_high
       && !fault_now && !armed) |=> s_q.ramp == $past(s_q.ramp) + 12'h001;
  endproperty
  a_ramp_moves: assert property (p_ramp_moves) else $error("ramp did not step on cycle start");

  property p_enable_fall_resets;
    @(posedge clk) disable iff (srst)
      (s_q.en_prev && !in_i.enable_high && (s_q.st == bfs_pkg::ST_FB_TEST || s_q.st == bfs_pkg::ST_RAMP
       || s_q.st == bfs_pkg::ST_RUN)) |=> s_q.st == bfs_pkg::ST_OFF && s_q.ramp == '0;
  endproperty
  a_enable_fall_resets: assert property (p_enable_fall_resets) else $error("enable fall did not reset");

  property p_sync_hs_off;
    @(posedge clk) disable iff (srst)
      s_q.o.low_side_sync |-> !s_q.o.high_side_on;
  endproperty
  a_sync_hs_off: assert property (p_sync_hs_off) else $error("both switches on");

  property p_uv_fault;
    @(posedge clk) disable iff (srst)
      (s_q.uv_cnt >= 5'(bfs_pkg::UV_CYCLES) && (s_q.st == bfs_pkg::ST_RAMP || s_q.st == bfs_pkg::ST_RUN)
       && in_i.supply_ok && in_i.enable_high) |=> s_q.o.fault_latched;
  endproperty
  a_uv_fault: assert property (p_uv_fault) else $error("undervoltage not latched");

  property p_ov_saturates;
    @(posedge clk) disable iff (srst)
      1'b1 |-> s_q.ov_cnt <= 5'(bfs_pkg::OV_CYCLES);
  endproperty
  a_ov_saturates: assert property (p_ov_saturates) else $error("overvoltage count overran");

  property p_hot_fault;
    @(posedge clk) disable iff (srst)
      (in_i.temp_hot && (s_q.st == bfs_pkg::ST_RAMP || s_q.st == bfs_pkg::ST_RUN)
       && in_i.supply_ok && in_i.enable_high) |=> s_q.o.fault_latched;
  endproperty
  a_hot_fault: assert property (p_hot_fault) else $error("over-temperature not latched");

  property p_warm_holds;
    @(posedge clk) disable iff (srst)
      (s_q.st == bfs_pkg::ST_FAULT_SINK && !in_i.temp_cool && in_i.supply_ok)
      |=> s_q.st == bfs_pkg::ST_FAULT_SINK;
  endproperty
  a_warm_holds: assert property (p_warm_holds) else $error("restart while die warm");

  property p_sink_in_fault;
    @(posedge clk) disable iff (srst)
      s_q.o.enable_sink |-> s_q.st == bfs_pkg::ST_FAULT_SINK;
  endproperty
  a_sink_in_fault: assert property (p_sink_in_fault) else $error("enable sunk outside fault");

  property p_wait_restart;
    @(posedge clk) disable iff (srst)
      (s_q.st == bfs_pkg::ST_FAULT_WAIT && in_i.enable_high && in_i.supply_ok)
      |=> s_q.st == bfs_pkg::ST_FB_TEST;
  endproperty
  a_wait_restart: assert property (p_wait_restart) else $error("no restart on enable rise");

  property p_sink_until_low;
    @(posedge clk) disable iff (srst)
      (s_q.st == bfs_pkg::ST_FAULT_SINK && !in_i.enable_low_thr && in_i.supply_ok)
      |=> s_q.st == bfs_pkg::ST_FAULT_SINK && s_q.o.enable_sink;
  endproperty
  a_sink_until_low: assert property (p_sink_until_low) else $error("sink released early");

  property p_pg_low_outside;
    @(posedge clk) disable iff (srst)
      !in_i.fb_pg_window |=> !s_q.o.power_good_out;
  endproperty
  a_pg_low_outside: assert property (p_pg_low_outside) else $error("power good out of regulation");

  property p_pulse_cut;
    @(posedge clk) disable iff (srst)
      pulse_end |=> !s_q.o.high_side_on;
  endproperty
  a_pulse_cut: assert property (p_pulse_cut) else $error("high side pulse not cut");

  property p_oc_fault;
    @(posedge clk) disable iff (srst)
      (s_q.oc_cnt >= 5'(bfs_pkg::OC_CYCLES) && (s_q.st == bfs_pkg::ST_RAMP || s_q.st == bfs_pkg::ST_RUN)
       && in_i.supply_ok && in_i.enable_high) |=> s_q.o.fault_latched;
  endproperty
  a_oc_fault: assert property (p_oc_fault) else $error("overcurrent not latched");

  property p_idle_no_drive;
    @(posedge clk) disable iff (srst)
      (s_q.st == bfs_pkg::ST_OFF || s_q.st == bfs_pkg::ST_FB_TEST)
      |-> !s_q.o.high_side_on && !s_q.o.low_side_sync;
  endproperty
  a_idle_no_drive: assert property (p_idle_no_drive) else $error("drive active before ramp");
endmodule

// ---- testbench/bfs_far_end.sv ----
// far-side model: enable pin network, oscillator pulse and pwm comparators
`timescale 1ns/100ps
module bfs_far_end (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [1:0] en_mode,
  input  wire logic       oc_mode,
  input  wire logic       high_side_on,
  input  wire logic       enable_sink,
  output logic            enable_high,
  output logic            enable_low_thr,
  output logic            cycle_start,
  output logic            err_amp_cross,
  output logic            cur_limit_cross
);
  // ------------------------------------------------
  // enable pin level, 0 = ground, 7 = fully pulled up
  // ------------------------------------------------
  logic [2:0] pin_q;
  initial begin
    pin_q = 3'h0;
    cycle_start = 1'b0;
  end
  always @(negedge clk) begin
    cycle_start <= srst ? 1'b0 : !cycle_start;
    if (srst || en_mode == 2'h0)
      pin_q <= 3'h0;
    else if (en_mode == 2'h1)
      pin_q <= 3'h7;
    else if (enable_sink)
      pin_q <= (pin_q == 3'h0) ? 3'h0 : pin_q - 3'h1;
    else if (pin_q != 3'h7)
      pin_q <= pin_q + 3'h1;
  end
  // thresholds apart so the pin shows hysteresis
  assign enable_high = pin_q >= 3'h6;
  assign enable_low_thr = pin_q <= 3'h2;
  assign err_amp_cross = high_side_on && !oc_mode;
  assign cur_limit_cross = high_side_on && oc_mode;
endmodule

// ---- testbench/tb_top.sv ----
// self-checking bench of the buck sequencer
`timescale 1ns/100ps
module tb_top;
  logic                     clk, srst, oc_mode, eh, el, cs, ea, cl;
  logic [1:0]               en_mode;
  int                       bad_count, checks_done, cycles;
  bfs_pkg::bfs_in_t         drv, din;
  bfs_pkg::bfs_out_t        q;
  logic [bfs_pkg::SS_W-1:0] r;
  always_comb begin
    din = drv;
    din.enable_high = eh;
    din.enable_low_thr = el;
    din.clock_cycle_start = cs;
    din.err_amp_cross = ea;
    din.cur_limit_cross = cl;
  end
  bfs_sequencer bfs_sequencer_i (.clk(clk), .srst(srst), .in_i(din), .out_o(q), .ramp_o(r));
  bfs_far_end bfs_far_end_i (.clk(clk), .srst(srst), .en_mode(en_mode), .oc_mode(oc_mode),
    .high_side_on(q.high_side_on), .enable_sink(q.enable_sink), .enable_high(eh), .enable_low_thr(el),
    .cycle_start(cs), .err_amp_cross(ea), .cur_limit_cross(cl));
  // ------------------------------------------------
  // shared tasks
  // ------------------------------------------------
  task automatic chk(string n, logic [11:0] e, logic [11:0] g);
    checks_done++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic boot(logic [1:0] m);
    drv = 13'h1048;  // supply up, die cool, feedback in window
    oc_mode = 1'b0;
    en_mode = m;
    srst = 1'b1;
    cyc(3);
    srst = 1'b0;
  endtask
  task automatic wait_ramp(logic [11:0] v);
    for (int i = 0; i < 6000 && r < v; i++) begin
      if (q.low_side_sync === 1'b1 && r < bfs_pkg::SS_SYNC_PT) chk("early_sync", 12'h0, 12'h1);
      if (q.power_good_out === 1'b1 && r < bfs_pkg::SS_ARM_PT) chk("early_pg", 12'h0, 12'h1);
      cyc(1);
    end
    chk("ramp_reached", 12'h1, r >= v);
  endtask
  task automatic results;
    if (bad_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  task automatic t_start_uv;
    boot(2'h2);
    wait_ramp(bfs_pkg::SS_ARM_PT);
    cyc(4);
    chk("pg_high", 12'h1, q.power_good_out);
    drv.fb_pg_window = 1'b0;
    cyc(4);
    chk("pg_low", 12'h0, q.power_good_out);
    drv.fb_uv = 1'b1;
    cyc(14);
    chk("uv_early", 12'h0, q.fault_latched);
    cyc(4);
    chk("uv_fault", 12'h1, q.fault_latched);
    chk("uv_sink", 12'h1, q.enable_sink);
    chk("uv_drives", 12'h0, {10'h000, q.high_side_on, q.low_side_sync});
    chk("uv_diode", 12'h0, q.low_side_diode);
    chk("uv_ramp", 12'h0, r);
    drv.fb_uv = 1'b0;
    wait_ramp(12'h20);
  endtask
  task automatic t_pre_ov;
    boot(2'h2);
    drv.fb_uv = 1'b1;
    wait_ramp(12'h900);
    chk("uv_disarmed", 12'h0, q.fault_latched);
    drv.fb_uv = 1'b0;
    drv.fb_ov = 1'b1;
    cyc(1);
    drv.fb_ov = 1'b0;
    cyc(3);
    chk("ov_single", 12'h0, q.fault_latched);
    drv.fb_ov = 1'b1;
    cyc(4);
    chk("ov_fault", 12'h1, q.fault_latched);
  endtask
  task automatic t_short_oc;
    boot(2'h2);
    drv.fb_short = 1'b1;
    cyc(200);
    chk("short_ramp", 12'h0, r);
    chk("short_drive", 12'h0, q.high_side_on);
    boot(2'h2);
    oc_mode = 1'b1;
    cyc(20);
    chk("oc_early", 12'h0, q.fault_latched);
    // auto-restart clears the latch again, so stop at the first latch
    for (int i = 0; i < 60 && q.fault_latched !== 1'b1; i++) cyc(1);
    chk("oc_fault", 12'h1, q.fault_latched);
  endtask
  task automatic t_hot_sw;
    boot(2'h2);
    wait_ramp(12'h40);
    drv.temp_hot = 1'b1;
    drv.temp_cool = 1'b0;
    cyc(3);
    chk("hot_fault", 12'h1, q.fault_latched);
    drv.temp_hot = 1'b0;
    cyc(100);
    chk("warm_held", 12'h1, q.fault_latched);
    drv.temp_cool = 1'b1;
    wait_ramp(12'h20);
    boot(2'h1);
    wait_ramp(12'h7a0);
    for (int i = 0; i < 20 && q.low_side_sync !== 1'b1; i++) cyc(1);
    drv.switch_node_high = 1'b1;
    cyc(2);
    chk("sw_fault", 12'h1, q.fault_latched);
    drv.switch_node_high = 1'b0;
    cyc(100);
    chk("held_latched", 12'h1, q.fault_latched);
  endtask
  task automatic t_rst;
    boot(2'h2);
    wait_ramp(12'h100);
    drv.supply_ok = 1'b0;
    cyc(3);
    chk("lockout_ramp", 12'h0, r);
    drv.supply_ok = 1'b1;
    wait_ramp(12'h40);
    en_mode = 2'h0;
    cyc(4);
    chk("grounded_ramp", 12'h0, r);
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // hang guard, well above the roughly 15k cycles of the run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      results();
    end
  end
  initial begin
    drv = 13'h1048;
    en_mode = 2'h0;
    oc_mode = 1'b0;
    srst = 1'b1;
    t_start_uv();
    t_pre_ov();
    t_short_oc();
    t_hot_sw();
    t_rst();
    results();
  end
endmodule
